// >>> core/frt_consts.svh
`ifndef FRT_CONSTS_SVH
`define FRT_CONSTS_SVH
// Overview of operation
// RL1: Sixteen-bit up-counter runs continuously on every selected timer tick.
// RL2: Tick source is cpu clock over 2, 4, 8 or external clock pin.
// RL3: External clock must be at most quarter cpu rate; software picks edge.
// RL4: With prescaler, count period is 131072, 262144 or 524288 cpu cycles.
// RL5: Counter readable as high and low bytes via main and alternate copies.
// RL6: Reading alternate low byte leaves the overflow flag untouched.
// RL7: Writing either low byte forces the counter to fffc.
// RL8: Counter resets to fffc in all modes; fffc is only reload value.
// RL9: Overflow sets a flag; interrupt raised only when enabled.
// RL10: Two compare channels with value, output pin, flag, shared interrupt.
// RL11: Two capture channels with value, edge select, flag, shared interrupt.
// RL12: Pulse-width and one-pulse modes besides plain compare and capture.
// RL13: Timer input from an unbonded pin reads as one.
// RL14: Separate instances share nothing and stay in step after reset.
// RL15: High byte read latches low byte for a coherent later low read.

// Byte addresses of the registers, one aligned word each
`define OFS_CTRL_TWO    12'h000
`define OFS_CTRL_ONE    12'h004
`define OFS_STATUS      12'h008
`define OFS_CAP1_HI     12'h00c
`define OFS_CAP1_LO     12'h010
`define OFS_CMP1_HI     12'h014
`define OFS_CMP1_LO     12'h018
`define OFS_CNT_HI      12'h01c
`define OFS_CNT_LO      12'h020
`define OFS_ALT_HI      12'h024
`define OFS_ALT_LO      12'h028
`define OFS_CAP2_HI     12'h02c
`define OFS_CAP2_LO     12'h030
`define OFS_CMP2_HI     12'h034
`define OFS_CMP2_LO     12'h038

// Control two fields
`define C2_CLKSEL_LO    0
`define C2_EXT_EDGE     2
`define C2_PWM          4
`define C2_OPM          5
`define C2_EDGE2        6
// Control one fields
`define C1_OLVL1        0
`define C1_OLVL2        1
`define C1_EDGE1        2
`define C1_OC_EN        3
`define C1_TOIE         5
`define C1_OCIE         6
`define C1_ICIE         7
// Status fields
`define SR_TOF          5
`define SR_OCF2         3
`define SR_ICF2         4
`define SR_OCF1         6
`define SR_ICF1         7

`define CNT_RELOAD      16'hfffc
`define CMP_RESET       16'h8000
`define PRESC_W         3
`endif

// >>> core/frt_pkg.sv
package frt_pkg;
    typedef enum logic [1:0] {
        CLK_DIV2 = 2'b00,
        CLK_DIV4 = 2'b01,
        CLK_DIV8 = 2'b10,
        CLK_EXT  = 2'b11
    } clk_sel_t;

    typedef enum logic [1:0] {
        OPM_IDLE  = 2'b00,
        OPM_PULSE = 2'b01,
        OPM_DONE  = 2'b10
    } opm_state_t;
endpackage : frt_pkg

// >>> core/frt_tick_if.sv
interface frt_tick_if;
    logic tick;
    logic edge1;
    logic edge2;
    modport src (output tick, output edge1, output edge2);
    modport dst (input tick, input edge1, input edge2);
endinterface : frt_tick_if

// >>> core/frt_tick_gen.sv
`include "frt_consts.svh"
module frt_tick_gen (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire frt_pkg::clk_sel_t sel,
    input  wire logic             ext_rise,
    input  wire logic             ext_clk_s,
    input  wire logic             cap1_s,
    input  wire logic             cap2_s,
    input  wire logic             cap1_rise,
    input  wire logic             cap2_rise,
    input  wire logic             restart,
    frt_tick_if.src               tk
);
    import frt_pkg::*;
    logic [`PRESC_W-1:0] presc_r, presc_nxt;
    logic                ext_d_r, ext_d_nxt;
    logic                c1_d_r, c1_d_nxt;
    logic                c2_d_r, c2_d_nxt;
    logic                tick_r, tick_nxt;
    logic                e1_r, e1_nxt;
    logic                e2_r, e2_nxt;

    always_comb begin
        presc_nxt = restart ? '0 : presc_r + 3'h1;
        ext_d_nxt = ext_clk_s;
        c1_d_nxt  = cap1_s;
        c2_d_nxt  = cap2_s;
        e1_nxt    = (cap1_s != c1_d_r) && (cap1_s == cap1_rise); // RL11
        e2_nxt    = (cap2_s != c2_d_r) && (cap2_s == cap2_rise); // RL11
        case (sel) // RL2
            CLK_DIV2: tick_nxt = presc_r[0];
            CLK_DIV4: tick_nxt = &presc_r[1:0];
            CLK_DIV8: tick_nxt = &presc_r;
            default:  tick_nxt = (ext_clk_s != ext_d_r)
                                 && (ext_clk_s == ext_rise); // RL3
        endcase
        if (restart && sel != CLK_EXT) begin
            tick_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            presc_r <= '0;
            ext_d_r <= 1'b1;
            c1_d_r  <= 1'b1;
            c2_d_r  <= 1'b1;
            tick_r  <= 1'b0;
            e1_r    <= 1'b0;
            e2_r    <= 1'b0;
        end else begin
            presc_r <= presc_nxt;
            ext_d_r <= ext_d_nxt;
            c1_d_r  <= c1_d_nxt;
            c2_d_r  <= c2_d_nxt;
            tick_r  <= tick_nxt;
            e1_r    <= e1_nxt;
            e2_r    <= e2_nxt;
        end
    end

    assign tk.tick  = tick_r;
    assign tk.edge1 = e1_r;
    assign tk.edge2 = e2_r;
endmodule : frt_tick_gen

// >>> core/frt_timer.sv
// Our own choices: the APB slave port and the address map.
`include "frt_consts.svh"
module frt_timer (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        capture_input_one,
    input  wire logic        capture_input_two,
    input  wire logic        external_timer_clock,
    output logic             compare_output_one,
    output logic             compare_output_two,
    output logic             timer_irq
);
    import frt_pkg::*;

    // Unbonded pins are expected tied high so they read as one (RL13)
    logic [2:0] sy1_r, sy2_r;
    logic       cap1_s, cap2_s, ext_s;

    logic [7:0]  ctl2_r, ctl2_nxt, ctl1_r, ctl1_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [15:0] cmp1_r, cmp1_nxt, cmp2_r, cmp2_nxt;
    logic [15:0] cap1_r, cap1_nxt, cap2_r, cap2_nxt;
    logic [7:0]  low_latch_r, low_latch_nxt;
    logic        tof_r, tof_nxt, ocf1_r, ocf1_nxt, ocf2_r, ocf2_nxt;
    logic        icf1_r, icf1_nxt, icf2_r, icf2_nxt;
    logic        sr_seen_r, sr_seen_nxt;
    logic        hold_r, hold_nxt;
    logic        out1_r, out1_nxt, out2_r, out2_nxt;
    logic        irq_r, irq_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        rdy_r, rdy_nxt, err_r, err_nxt;
    opm_state_t  opm_r, opm_nxt;

    logic        acc, wr, rd, low_wr, restart, opm_go;
    logic [7:0]  rbyte;
    logic        rvalid;
    frt_tick_if  tk ();

    // Two-stage synchronisers; the first stage feeds only the second
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sy1_r <= 3'h7; // RL13
            sy2_r <= 3'h7;
        end else begin
            sy1_r <= {external_timer_clock, capture_input_two,
                      capture_input_one};
            sy2_r <= sy1_r;
        end
    end
    assign cap1_s = sy2_r[0];
    assign cap2_s = sy2_r[1];
    assign ext_s  = sy2_r[2];

    // Access phase completes in the same cycle pready is seen high
    assign acc     = psel && penable && rdy_r;
    assign wr      = acc && pwrite;
    assign rd      = acc && !pwrite;
    assign low_wr  = wr && (paddr == `OFS_CNT_LO
                            || paddr == `OFS_ALT_LO); // RL7
    assign restart = low_wr;
    // A capture edge arms the one-shot only once until the mode is left
    assign opm_go  = tk.edge1 && ctl2_r[`C2_OPM] && opm_r == OPM_IDLE;

    frt_tick_gen u_tick (
        .clock     (clock),
        .rst_n     (rst_n),
        .sel       (clk_sel_t'(ctl2_r[1:0])),
        .ext_rise  (ctl2_r[`C2_EXT_EDGE]),
        .ext_clk_s (ext_s),
        .cap1_s    (cap1_s),
        .cap2_s    (cap2_s),
        .cap1_rise (ctl1_r[`C1_EDGE1]),
        .cap2_rise (ctl2_r[`C2_EDGE2]),
        .restart   (restart),
        .tk        (tk)
    );

    function automatic logic [7:0] pick(input logic hi_sel,
                                        input logic [15:0] v);
        pick = hi_sel ? v[15:8] : v[7:0];
    endfunction : pick

    // Read decode
    always_comb begin
        rbyte  = 8'h00;
        rvalid = 1'b1;
        if (paddr == `OFS_CTRL_TWO) begin
            rbyte = ctl2_r;
        end else if (paddr == `OFS_CTRL_ONE) begin
            rbyte = ctl1_r;
        end else if (paddr == `OFS_STATUS) begin
            rbyte = {icf1_r, ocf1_r, tof_r, icf2_r, ocf2_r, 3'b000};
        end else if (paddr == `OFS_CAP1_HI) begin
            rbyte = pick(1'b1, cap1_r);
        end else if (paddr == `OFS_CAP1_LO) begin
            rbyte = pick(1'b0, cap1_r);
        end else if (paddr == `OFS_CMP1_HI) begin
            rbyte = pick(1'b1, cmp1_r);
        end else if (paddr == `OFS_CMP1_LO) begin
            rbyte = pick(1'b0, cmp1_r);
        end else if (paddr == `OFS_CNT_HI || paddr == `OFS_ALT_HI) begin
            rbyte = cnt_r[15:8]; // RL5
        end else if (paddr == `OFS_CNT_LO || paddr == `OFS_ALT_LO) begin
            rbyte = hold_r ? low_latch_r : cnt_r[7:0]; // RL15
        end else if (paddr == `OFS_CAP2_HI) begin
            rbyte = pick(1'b1, cap2_r);
        end else if (paddr == `OFS_CAP2_LO) begin
            rbyte = pick(1'b0, cap2_r);
        end else if (paddr == `OFS_CMP2_HI) begin
            rbyte = pick(1'b1, cmp2_r);
        end else if (paddr == `OFS_CMP2_LO) begin
            rbyte = pick(1'b0, cmp2_r);
        end else begin
            rvalid = 1'b0;
        end
    end

    // Bus answer: no wait state, pready pulses for one cycle
    always_comb begin
        rdy_nxt   = psel && !penable ? 1'b1 : 1'b0;
        rdata_nxt = rdata_r;
        err_nxt   = 1'b0;
        if (psel && !penable) begin
            rdata_nxt = {24'h000000, rbyte};
            err_nxt   = !rvalid;
        end
    end

    // Counter, compare, capture and flags
    always_comb begin
        cnt_nxt       = cnt_r;
        ctl1_nxt      = ctl1_r;
        ctl2_nxt      = ctl2_r;
        cmp1_nxt      = cmp1_r;
        cmp2_nxt      = cmp2_r;
        cap1_nxt      = cap1_r;
        cap2_nxt      = cap2_r;
        low_latch_nxt = low_latch_r;
        tof_nxt       = tof_r;
        ocf1_nxt      = ocf1_r;
        ocf2_nxt      = ocf2_r;
        icf1_nxt      = icf1_r;
        icf2_nxt      = icf2_r;
        sr_seen_nxt   = sr_seen_r;
        hold_nxt      = hold_r;
        out1_nxt      = out1_r;
        out2_nxt      = out2_r;
        opm_nxt       = opm_r;

        if (rd && paddr == `OFS_STATUS) begin
            sr_seen_nxt = 1'b1;
        end
        // Flag clear needs a status read first, then a data access
        if (sr_seen_r && rd && paddr == `OFS_CNT_LO) begin
            tof_nxt     = 1'b0; // RL6
            sr_seen_nxt = 1'b0;
        end
        if (sr_seen_r && rd && paddr == `OFS_CAP1_LO) begin
            icf1_nxt = 1'b0;
        end
        if (sr_seen_r && rd && paddr == `OFS_CAP2_LO) begin
            icf2_nxt = 1'b0;
        end
        if (sr_seen_r && wr && paddr == `OFS_CMP1_LO) begin
            ocf1_nxt = 1'b0;
        end
        if (sr_seen_r && wr && paddr == `OFS_CMP2_LO) begin
            ocf2_nxt = 1'b0;
        end
        // Latch at the high byte's setup, the edge its data is taken
        if (psel && !penable && !pwrite
            && (paddr == `OFS_CNT_HI || paddr == `OFS_ALT_HI)) begin
            low_latch_nxt = cnt_r[7:0]; // RL15
            hold_nxt      = 1'b1;
        end else if (acc && (paddr == `OFS_CNT_LO
                             || paddr == `OFS_ALT_LO)) begin
            hold_nxt = 1'b0;
        end

        if (wr) begin
            if (paddr == `OFS_CTRL_TWO) begin
                ctl2_nxt = pwdata[7:0];
            end else if (paddr == `OFS_CTRL_ONE) begin
                ctl1_nxt = pwdata[7:0];
            end else if (paddr == `OFS_CMP1_HI) begin
                cmp1_nxt[15:8] = pwdata[7:0];
            end else if (paddr == `OFS_CMP1_LO) begin
                cmp1_nxt[7:0] = pwdata[7:0];
            end else if (paddr == `OFS_CMP2_HI) begin
                cmp2_nxt[15:8] = pwdata[7:0];
            end else if (paddr == `OFS_CMP2_LO) begin
                cmp2_nxt[7:0] = pwdata[7:0];
            end
        end

        // Capture: set wins over a clear in the same cycle
        if (tk.edge1) begin
            cap1_nxt = cnt_r; // RL11
            icf1_nxt = 1'b1;
            if (opm_go) begin
                opm_nxt  = OPM_PULSE; // RL12
                out1_nxt = ctl1_r[`C1_OLVL2];
            end
        end
        if (tk.edge2 && !ctl2_r[`C2_PWM]) begin
            cap2_nxt = cnt_r; // RL11
            icf2_nxt = 1'b1;
        end

        if (low_wr) begin
            cnt_nxt = `CNT_RELOAD; // RL7
        end else if (opm_go) begin
            // A tick in the same cycle must not swallow the reload
            cnt_nxt = `CNT_RELOAD; // RL8
        end else if (tk.tick) begin
            cnt_nxt = cnt_r + 16'h0001; // RL1 RL4
            if (cnt_r == 16'hffff) begin
                tof_nxt = 1'b1; // RL9
            end
            if (cnt_nxt == cmp1_r) begin
                ocf1_nxt = ocf1_nxt || !ctl2_r[`C2_PWM]; // RL10
                if (ctl1_r[`C1_OC_EN]) begin
                    out1_nxt = ctl1_r[`C1_OLVL1];
                end
            end
            if (cnt_nxt == cmp2_r) begin
                ocf2_nxt = ocf2_nxt || !ctl2_r[`C2_PWM]; // RL10
                if (ctl1_r[`C1_OC_EN]) begin
                    out2_nxt = ctl1_r[`C1_OLVL2];
                end
            end
            // Pulse-width: compare 1 sets the edge, compare 2 restarts
            if (ctl2_r[`C2_PWM] && cnt_nxt == cmp2_r) begin
                cnt_nxt  = `CNT_RELOAD; // RL12 RL8
                out1_nxt = ctl1_r[`C1_OLVL2];
            end else if (ctl2_r[`C2_PWM] && cnt_nxt == cmp1_r) begin
                out1_nxt = ctl1_r[`C1_OLVL1]; // RL12
            end
            if (opm_r == OPM_PULSE && cnt_nxt == cmp1_r) begin
                out1_nxt = ctl1_r[`C1_OLVL1]; // RL12
                opm_nxt  = OPM_DONE;
            end
        end
        if (!ctl2_r[`C2_OPM]) begin
            opm_nxt = OPM_IDLE;
        end
    end

    always_comb begin
        irq_nxt = (tof_r && ctl1_r[`C1_TOIE])
                  || ((ocf1_r || ocf2_r) && ctl1_r[`C1_OCIE])
                  || ((icf1_r || icf2_r) && ctl1_r[`C1_ICIE]); // RL9
    end

    // Each instance owns all its state, so two stay in step (RL14)
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_r       <= `CNT_RELOAD; // RL8 RL14
            ctl1_r      <= 8'h00;
            ctl2_r      <= 8'h00;
            cmp1_r      <= `CMP_RESET;
            cmp2_r      <= `CMP_RESET;
            cap1_r      <= 16'h0000;
            cap2_r      <= 16'h0000;
            low_latch_r <= 8'hfc;
            tof_r       <= 1'b0;
            ocf1_r      <= 1'b0;
            ocf2_r      <= 1'b0;
            icf1_r      <= 1'b0;
            icf2_r      <= 1'b0;
            sr_seen_r   <= 1'b0;
            hold_r      <= 1'b0;
            out1_r      <= 1'b0;
            out2_r      <= 1'b0;
            opm_r       <= OPM_IDLE;
            irq_r       <= 1'b0;
            rdata_r     <= 32'h00000000;
            rdy_r       <= 1'b0;
            err_r       <= 1'b0;
        end else begin
            cnt_r       <= cnt_nxt;
            ctl1_r      <= ctl1_nxt;
            ctl2_r      <= ctl2_nxt;
            cmp1_r      <= cmp1_nxt;
            cmp2_r      <= cmp2_nxt;
            cap1_r      <= cap1_nxt;
            cap2_r      <= cap2_nxt;
            low_latch_r <= low_latch_nxt;
            tof_r       <= tof_nxt;
            ocf1_r      <= ocf1_nxt;
            ocf2_r      <= ocf2_nxt;
            icf1_r      <= icf1_nxt;
            icf2_r      <= icf2_nxt;
            sr_seen_r   <= sr_seen_nxt;
            hold_r      <= hold_nxt;
            out1_r      <= out1_nxt;
            out2_r      <= out2_nxt;
            opm_r       <= opm_nxt;
            irq_r       <= irq_nxt;
            rdata_r     <= rdata_nxt;
            rdy_r       <= rdy_nxt;
            err_r       <= err_nxt;
        end
    end

    assign prdata             = rdata_r;
    assign pready             = rdy_r;
    assign pslverr            = err_r;
    assign compare_output_one = out1_r;
    assign compare_output_two = out2_r;
    assign timer_irq          = irq_r;
endmodule : frt_timer

// >>> test/frt_timer_properties.sv
`include "frt_consts.svh"
module frt_timer_properties (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        capture_input_one,
    input wire logic        capture_input_two,
    input wire logic        external_timer_clock,
    input wire logic        compare_output_one,
    input wire logic        compare_output_two,
    input wire logic        timer_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_unmapped: assert property (
        psel && !penable && paddr > `OFS_CMP2_LO |=> pslverr)
        else $error("unmapped access not refused");
    a_ok_mapped: assert property (psel && !penable &&
        paddr <= `OFS_CMP2_LO && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("mapped access refused");
    a_upper_zero: assert property (
        pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("read data wider than a byte");
    // Software may read late, so the data must outlive the access
    a_rdata_hold: assert property (!psel |-> $stable(prdata))
        else $error("read data changed while idle");
    a_rst_quiet: assert property ($rose(rst_n) |-> !pready &&
        !timer_irq && !compare_output_one && !compare_output_two)
        else $error("outputs active after reset");
    a_irq_masked: assert property (
        psel && penable && pready && pwrite &&
        paddr == `OFS_CTRL_ONE && pwdata[7:5] == 3'b000 |-> ##2 !timer_irq)
        else $error("interrupt raised while masked");

    c_refused: cover property (pready && pslverr);
    c_irq: cover property ($rose(timer_irq));
    c_compare: cover property ($rose(compare_output_one));
endmodule : frt_timer_properties

bind frt_timer frt_timer_properties frt_timer_properties_i (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .capture_input_one(capture_input_one),
    .capture_input_two(capture_input_two),
    .external_timer_clock(external_timer_clock),
    .compare_output_one(compare_output_one),
    .compare_output_two(compare_output_two), .timer_irq(timer_irq));

// >>> test/frt_pins_model.sv
module frt_pins_model (
    input  wire logic clock,
    input  wire logic compare_output_one,
    output logic      capture_input_one,
    output logic      capture_input_two,
    output logic      external_timer_clock
);
    timeunit 1ns;
    timeprecision 1ns;
    int   rises;
    logic last_r;
    // Idle capture pins sit high, as an unbonded pin would
    initial begin
        capture_input_one = 1'b1;
        capture_input_two = 1'b1;
        external_timer_clock = 1'b0;
    end
    always @(posedge clock) begin
        last_r <= compare_output_one;
        if (compare_output_one === 1'b1 && last_r === 1'b0) begin
            rises <= rises + 1;
        end
    end
    // Eight-clock period keeps the pin under a quarter of the cpu rate
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge clock);
            external_timer_clock <= 1'b1;
            repeat (4) @(posedge clock);
            external_timer_clock <= 1'b0;
            repeat (3) @(posedge clock);
        end
    endtask : ext_pulses
    task automatic cap_pulse;
        @(posedge clock);
        capture_input_one <= 1'b0;
        capture_input_two <= 1'b0;
        repeat (4) @(posedge clock);
        capture_input_one <= 1'b1;
        capture_input_two <= 1'b1;
    endtask : cap_pulse
endmodule : frt_pins_model

// >>> test/testbench.sv
`include "frt_consts.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import frt_pkg::*;
    logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        cap1, cap2, ext_clk, out1, out2, timer_irq;
    logic [7:0]  v, hi, lo;
    int          n_mismatch, tests_run, n0;
    logic [11:0] rofs [6] = '{`OFS_CTRL_TWO, `OFS_CTRL_ONE, `OFS_CMP1_HI,
                              `OFS_CMP1_LO, `OFS_CMP2_HI, `OFS_CMP2_LO};
    logic [7:0]  rexp [6] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00};

    frt_timer frt_timer_i (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_input_one(cap1), .capture_input_two(cap2),
        .external_timer_clock(ext_clk), .compare_output_one(out1),
        .compare_output_two(out2), .timer_irq(timer_irq));
    frt_pins_model frt_pins_model_i (.clock(clock), .compare_output_one(out1),
        .capture_input_one(cap1), .capture_input_two(cap2),
        .external_timer_clock(ext_clk));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Holds the request until pready is sampled, then idles one cycle
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        check("pready", {7'h00, pready}, 8'h01);
        v = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a);
        xfer(1'b0, a, 8'h00);
    endtask : rd

    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        // Counter runs from release, so it is read before it wraps
        rd(`OFS_CNT_HI);
        check("count high after reset", v, 8'hff);
        repeat (16) @(posedge clock);
        rd(`OFS_CNT_LO);
        check("coherent low", 8'(v >= 8'hfc), 8'h01);
        foreach (rofs[i]) begin
            rd(rofs[i]);
            check("reset value", v, rexp[i]);
        end
        xfer(1'b0, 12'h03c, 8'h00);
        check("unmapped read", {7'h00, err}, 8'h01);
        xfer(1'b1, 12'h100, 8'h55);
        check("unmapped write", {7'h00, err}, 8'h01);
        // Any written value reloads; main and alternate low both tried
        for (int i = 0; i < 3; i++) begin
            wr(`OFS_CTRL_TWO, 8'(i));
            wr(i == 1 ? `OFS_ALT_LO : `OFS_CNT_LO, 8'h5a);
            repeat (64) @(posedge clock);
            rd(`OFS_CNT_HI);
            hi = v;
            rd(`OFS_CNT_LO);
            lo = v;
            check("rate high", hi, 8'h00);
            check("rate low", 8'(8'(lo - 8'hfc - 8'(64 >> (i + 1))) < 8'd4),
                  8'h01);
            rd(`OFS_ALT_HI);
            check("alt high", v, hi);
            rd(`OFS_ALT_LO);
            check("alt low", 8'(8'(v - lo) < 8'd4), 8'h01);
        end
        wr(`OFS_CTRL_TWO, 8'h07);
        wr(`OFS_CNT_LO, 8'h00);
        frt_pins_model_i.ext_pulses(10);
        repeat (8) @(posedge clock);
        rd(`OFS_CNT_HI);
        check("ext high", v, 8'h00);
        rd(`OFS_CNT_LO);
        check("ext low", v, 8'h06);
        wr(`OFS_CTRL_TWO, 8'h00);
        wr(`OFS_CTRL_ONE, 8'h00);
        wr(`OFS_CNT_LO, 8'h00);
        repeat (16) @(posedge clock);
        check("irq masked", {7'h00, timer_irq}, 8'h00);
        rd(`OFS_STATUS);
        check("overflow set", {7'h00, v[`SR_TOF]}, 8'h01);
        rd(`OFS_ALT_LO);
        wr(`OFS_CTRL_ONE, 8'h20);
        repeat (3) @(posedge clock);
        check("irq enabled", {7'h00, timer_irq}, 8'h01);
        rd(`OFS_STATUS);
        check("overflow kept", {7'h00, v[`SR_TOF]}, 8'h01);
        rd(`OFS_CNT_LO);
        rd(`OFS_STATUS);
        check("overflow cleared", {7'h00, v[`SR_TOF]}, 8'h00);
        wr(`OFS_CTRL_ONE, 8'h4b);
        wr(`OFS_CMP1_HI, 8'h00);
        wr(`OFS_CMP1_LO, 8'h20);
        wr(`OFS_CMP2_HI, 8'h00);
        wr(`OFS_CMP2_LO, 8'h10);
        wr(`OFS_CNT_LO, 8'h00);
        repeat (120) @(posedge clock);
        check("compare one pin", {7'h00, out1}, 8'h01);
        check("compare two pin", {7'h00, out2}, 8'h01);
        check("compare irq", {7'h00, timer_irq}, 8'h01);
        rd(`OFS_STATUS);
        check("compare flags", v & 8'h48, 8'h48);
        wr(`OFS_CTRL_ONE, 8'h84);
        wr(`OFS_CTRL_TWO, 8'h40);
        frt_pins_model_i.cap_pulse();
        repeat (8) @(posedge clock);
        rd(`OFS_STATUS);
        check("capture flags", v & 8'h90, 8'h90);
        check("capture irq", {7'h00, timer_irq}, 8'h01);
        wr(`OFS_CTRL_ONE, 8'h09);
        wr(`OFS_CMP1_LO, 8'h08);
        wr(`OFS_CMP2_LO, 8'h20);
        wr(`OFS_CTRL_TWO, 8'h10);
        wr(`OFS_CNT_LO, 8'h00);
        n0 = frt_pins_model_i.rises;
        repeat (400) @(posedge clock);
        check("pwm pulses",
              8'(frt_pins_model_i.rises - n0 >= 3), 8'h01);
        wr(`OFS_CTRL_TWO, 8'h20);
        wr(`OFS_CTRL_ONE, 8'h0e);
        frt_pins_model_i.cap_pulse();
        repeat (8) @(posedge clock);
        check("one-pulse start", {7'h00, out1}, 8'h01);
        repeat (40) @(posedge clock);
        check("one-pulse end", {7'h00, out1}, 8'h00);
        frt_pins_model_i.cap_pulse();
        repeat (8) @(posedge clock);
        check("one-pulse once", {7'h00, out1}, 8'h00);
        wrap_up();
    end
endmodule : testbench
